// ### logic/ssipmf_formatter.sv
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module ssipmf_formatter #(
	parameter ssipmf_pkg::ssipmf_format_e FORMAT = ssipmf_pkg::format_one
)(
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire ssipmf_pkg::ssipmf_meas_s meas,
	input  wire logic                     sclk_pin,
	output logic                          sdata_pin,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr
);

	function automatic logic [21:0] res_mask(input logic [4:0] res);
		res_mask = (22'h000001 << res) - 22'h000001;
	endfunction : res_mask

	function automatic logic [4:0] res_limit(input ssipmf_pkg::ssipmf_format_e fmt);
		case (fmt)
			ssipmf_pkg::format_three, ssipmf_pkg::format_five: res_limit = ssipmf_pkg::RES_16;
			ssipmf_pkg::format_eight:                          res_limit = ssipmf_pkg::RES_18;
			ssipmf_pkg::format_four, ssipmf_pkg::format_nine:  res_limit = ssipmf_pkg::RES_19;
			default:                                           res_limit = ssipmf_pkg::RES_22;
		endcase
	endfunction : res_limit

	function automatic logic [21:0] to_gray(input logic [21:0] b);
		to_gray = b ^ (b >> 1);
	endfunction : to_gray

	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		c = ssipmf_pkg::CRC_INIT;
		for (int i = 23; i >= 0; i--)
		begin
			if (c[7] ^ d[i])
				c = (c << 1) ^ ssipmf_pkg::CRC_POLY;
			else
				c = c << 1;
		end
		crc8 = c;
	endfunction : crc8

	function automatic logic [5:0] msg_len(input ssipmf_pkg::ssipmf_format_e fmt);
		case (fmt)
			ssipmf_pkg::format_three, ssipmf_pkg::format_five: msg_len = ssipmf_pkg::LEN_16;
			ssipmf_pkg::format_eight:                          msg_len = ssipmf_pkg::LEN_18;
			ssipmf_pkg::format_seven:                          msg_len = ssipmf_pkg::LEN_30;
			ssipmf_pkg::format_four, ssipmf_pkg::format_six,
			ssipmf_pkg::format_nine:                           msg_len = ssipmf_pkg::LEN_32;
			default:                                           msg_len = ssipmf_pkg::LEN_24;
		endcase
	endfunction : msg_len

	function automatic logic [31:0] build(input ssipmf_pkg::ssipmf_format_e fmt, input logic [21:0] m,
		input logic err, input logic zdef, input logic [10:0] ts);
		logic [21:0] g;
		logic [23:0] lo;
		g  = to_gray(m);
		lo = {~err, zdef, m};
		case (fmt)
			ssipmf_pkg::format_two:   build = {8'h00, m, ^m, err};
			ssipmf_pkg::format_three: build = {16'h0000, m[15:0]};
			ssipmf_pkg::format_four,
			ssipmf_pkg::format_nine:  build = {~err, zdef, m[18:0], ts};
			ssipmf_pkg::format_five:  build = {16'h0000, g[15:0]};
			ssipmf_pkg::format_six:   build = {crc8(lo), lo};
			ssipmf_pkg::format_seven: build = {2'h0, 6'h00, m, ^m, err};
			ssipmf_pkg::format_eight: build = {14'h0000, g[17:0]};
			default:                  build = {8'h00, lo};
		endcase
	endfunction : build

	localparam logic [5:0]  LEN      = msg_len(FORMAT);
	localparam logic [4:0]  RES_LIM  = res_limit(FORMAT);
	localparam logic [6:0]  TS_STEP  = (FORMAT == ssipmf_pkg::format_nine) ? 7'(ssipmf_pkg::TS9_CYC)
		: 7'(ssipmf_pkg::TS4_CYC);
	localparam logic [7:0]  TMU_LAST = 8'(ssipmf_pkg::TMU_CYC - 1);

	logic                           sclk_meta;
	logic                           sclk_sync;
	logic                           sclk_prev;
	logic                           sclk_fall;
	logic                           sclk_rise;
	ssipmf_pkg::ssipmf_state_e      state;
	logic [31:0]                    shadow;
	logic [5:0]                     bits_left;
	logic [7:0]                     gap;
	logic                           gap_done;
	logic                           next_bit;
	logic                           trail_bit;
	logic [6:0]                     ts_pre;
	logic                           ts_tick;
	logic [10:0]                    ts_count;
	logic [21:0]                    last_pos;
	logic                           last_err;
	logic [10:0]                    last_ts;
	logic [1:0]                     ctrl;
	logic [4:0]                     res;
	logic [4:0]                     eff_res;
	logic                           err_now;
	logic                           zero_default_flag;
	logic [31:0]                    next_prdata;
	logic                           addr_ok;

	// Serial clock pin synchroniser and edge detection
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sclk_meta <= 1'b1;
			sclk_sync <= 1'b1;
			sclk_prev <= 1'b1;
		end
		else
		begin
			sclk_meta <= sclk_pin;
			sclk_sync <= sclk_meta;
			sclk_prev <= sclk_sync;
		end
	end

	assign sclk_fall = sclk_prev & ~sclk_sync;
	assign sclk_rise = ~sclk_prev & sclk_sync;

	// Free-running timestamp counter, wraps at full count
	assign ts_tick = (ts_pre == TS_STEP - 7'h01);

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ts_pre   <= 7'h00;
			ts_count <= 11'h000;
		end
		else if (ts_tick)
		begin
			ts_pre   <= 7'h00;
			ts_count <= ts_count + 11'h001;
		end
		else
			ts_pre   <= ts_pre + 7'h01;
	end

	// Latest measurement with its timestamp
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			last_pos <= 22'h000000;
			last_err <= 1'b1;
			last_ts  <= 11'h000;
		end
		else if (meas.strobe)
		begin
			last_pos <= meas.position_word;
			last_err <= meas.error;
			last_ts  <= ts_count;
		end
	end

	assign eff_res           = (res > RES_LIM) ? RES_LIM : res;
	assign err_now           = last_err | ctrl[ssipmf_pkg::CTRL_FORCE_ALARM];
	assign zero_default_flag = ~ctrl[ssipmf_pkg::CTRL_USER_ZERO];
	assign next_bit          = (bits_left != 6'h00) ? shadow[5'(bits_left - 6'h01)] : err_now;
	assign gap_done          = (gap == TMU_LAST);

	// Update gap timer, restarted at every falling clock edge
	always_ff @(posedge core_clk)
	begin
		if (rst || state == ssipmf_pkg::st_idle || sclk_fall)
			gap <= 8'h00;
		else if (!gap_done)
			gap <= gap + 8'h01;
	end

	// Read cycle sequencer
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state     <= ssipmf_pkg::st_idle;
			shadow    <= 32'h00000000;
			bits_left <= 6'h00;
			sdata_pin <= 1'b1;
			trail_bit <= 1'b0;
		end
		else
		begin
			case (state)
				ssipmf_pkg::st_idle:
				begin
					sdata_pin <= 1'b1;
					if (sclk_fall)
					begin
						shadow    <= build(FORMAT, last_pos & res_mask(eff_res), err_now,
							zero_default_flag, last_ts);
						bits_left <= LEN;
						state     <= ssipmf_pkg::st_shift;
					end
				end
				ssipmf_pkg::st_shift:
				begin
					if (gap_done)
					begin
						sdata_pin <= 1'b1;
						state     <= ssipmf_pkg::st_idle;
					end
					else if (sclk_rise)
					begin
						sdata_pin <= next_bit;
						if (bits_left != 6'h00)
							bits_left <= bits_left - 6'h01;
						else
						begin
							trail_bit <= next_bit;
							state     <= ssipmf_pkg::st_trail;
						end
					end
				end
				ssipmf_pkg::st_trail:
				begin
					if (gap_done)
					begin
						sdata_pin <= 1'b1;
						state     <= ssipmf_pkg::st_idle;
					end
				end
				default:
				begin
					sdata_pin <= 1'b1;
					state     <= ssipmf_pkg::st_idle;
				end
			endcase
		end
	end

	// APB slave, zero wait states
	assign pready  = 1'b1;
	assign addr_ok = (paddr == ssipmf_pkg::OFF_CTRL) || (paddr == ssipmf_pkg::OFF_RES)
		|| (paddr == ssipmf_pkg::OFF_STATUS) || (paddr == ssipmf_pkg::OFF_TSTAMP)
		|| (paddr == ssipmf_pkg::OFF_SHADOW);
	assign pslverr = psel & penable & ~addr_ok;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctrl <= ssipmf_pkg::CTRL_RST;
			res  <= ssipmf_pkg::RES_RST;
		end
		else if (psel && penable && pwrite)
		begin
			if (paddr == ssipmf_pkg::OFF_CTRL)
				ctrl <= pwdata[1:0];
			else if (paddr == ssipmf_pkg::OFF_RES)
				res  <= (pwdata[4:0] > ssipmf_pkg::RES_22) ? ssipmf_pkg::RES_22 : pwdata[4:0];
		end
	end

	always_comb
	begin
		if (paddr == ssipmf_pkg::OFF_CTRL)
			next_prdata = {30'h00000000, ctrl};
		else if (paddr == ssipmf_pkg::OFF_RES)
			next_prdata = {27'h0000000, res};
		else if (paddr == ssipmf_pkg::OFF_STATUS)
			next_prdata = {20'h00000, FORMAT, err_now, zero_default_flag, state, bits_left == 6'h00,
				state != ssipmf_pkg::st_idle, sdata_pin, sclk_sync};
		else if (paddr == ssipmf_pkg::OFF_TSTAMP)
			next_prdata = {21'h000000, ts_count};
		else if (paddr == ssipmf_pkg::OFF_SHADOW)
			next_prdata = shadow;
		else
			next_prdata = 32'h00000000;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= next_prdata;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_idle_high;
		state == ssipmf_pkg::st_idle && $past(state) == ssipmf_pkg::st_idle |-> sdata_pin;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("Data not high in idle");

	property p_shift_bit;
		state == ssipmf_pkg::st_shift && sclk_rise && !gap_done |=> sdata_pin == $past(next_bit);
	endproperty
	a_shift_bit: assert property (p_shift_bit) else $error("Shifted bit does not match message");

	property p_latch_start;
		state == ssipmf_pkg::st_idle && sclk_fall |=> state == ssipmf_pkg::st_shift && bits_left == LEN;
	endproperty
	a_latch_start: assert property (p_latch_start) else $error("Read did not start on falling edge");

	property p_shadow_hold;
		state != ssipmf_pkg::st_idle && $past(state) != ssipmf_pkg::st_idle |-> $stable(shadow);
	endproperty
	a_shadow_hold: assert property (p_shadow_hold) else $error("Message changed during read");

	property p_trail_hold;
		state == ssipmf_pkg::st_trail && $past(state) == ssipmf_pkg::st_trail |-> sdata_pin == trail_bit;
	endproperty
	a_trail_hold: assert property (p_trail_hold) else $error("Error bit not held after read");

	property p_gap_end;
		state == ssipmf_pkg::st_trail && $past(state) == ssipmf_pkg::st_shift
			|-> ##[1:199] state == ssipmf_pkg::st_idle ##1 sdata_pin;
	endproperty
	a_gap_end: assert property (p_gap_end) else $error("Data not back high after update gap");

	property p_parity;
		(FORMAT == ssipmf_pkg::format_two || FORMAT == ssipmf_pkg::format_seven)
			&& state == ssipmf_pkg::st_shift |-> (^shadow[23:1]) == 1'b0;
	endproperty
	a_parity: assert property (p_parity) else $error("Parity bit wrong");

	property p_crc;
		FORMAT == ssipmf_pkg::format_six && state == ssipmf_pkg::st_shift
			|-> shadow[31:24] == crc8(shadow[23:0]);
	endproperty
	a_crc: assert property (p_crc) else $error("CRC field wrong");

	property p_res_mask;
		(FORMAT == ssipmf_pkg::format_one || FORMAT == ssipmf_pkg::format_six)
			&& state == ssipmf_pkg::st_shift && $past(state) == ssipmf_pkg::st_idle
			|-> (shadow[21:0] & ~res_mask($past(eff_res))) == 22'h000000;
	endproperty
	a_res_mask: assert property (p_res_mask) else $error("Unused position bits not zero");

	property p_ts_step;
		ts_tick |=> ts_count == 11'($past(ts_count) + 11'h001) ##1 !ts_tick;
	endproperty
	a_ts_step: assert property (p_ts_step) else $error("Timestamp step wrong");

	property p_zero_flag;
		(FORMAT == ssipmf_pkg::format_one || FORMAT == ssipmf_pkg::format_six)
			&& state == ssipmf_pkg::st_idle && sclk_fall |=> shadow[22] == $past(zero_default_flag);
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("Zero default flag wrong");

endmodule : ssipmf_formatter

`default_nettype wire

// ### common/ssipmf_pkg.sv
`default_nettype none

package ssipmf_pkg;

	typedef enum logic [3:0]
	{
		format_one   = 4'h1,
		format_two   = 4'h2,
		format_three = 4'h3,
		format_four  = 4'h4,
		format_five  = 4'h5,
		format_six   = 4'h6,
		format_seven = 4'h7,
		format_eight = 4'h8,
		format_nine  = 4'h9
	} ssipmf_format_e;

	typedef enum logic [1:0]
	{
		st_idle  = 2'b00,
		st_shift = 2'b01,
		st_trail = 2'b10
	} ssipmf_state_e;

	typedef struct packed
	{
		logic        strobe;
		logic        error;
		logic [21:0] position_word;
	} ssipmf_meas_s;

	localparam int          CLK_HZ       = 10_000_000;
	localparam int          TMU_US       = 20;
	localparam int          TMU_CYC      = TMU_US * (CLK_HZ / 1_000_000);
	localparam int          TS4_STEP_US  = 10;
	localparam int          TS4_CYC      = TS4_STEP_US * (CLK_HZ / 1_000_000);
	localparam int          TS9_STEP_US  = 1;
	localparam int          TS9_CYC      = TS9_STEP_US * (CLK_HZ / 1_000_000);

	localparam logic [7:0]  CRC_POLY     = 8'h97;
	localparam logic [7:0]  CRC_INIT     = 8'h00;

	localparam logic [5:0]  LEN_16       = 6'h10;
	localparam logic [5:0]  LEN_18       = 6'h12;
	localparam logic [5:0]  LEN_24       = 6'h18;
	localparam logic [5:0]  LEN_30       = 6'h1e;
	localparam logic [5:0]  LEN_32       = 6'h20;

	localparam logic [4:0]  RES_16       = 5'h10;
	localparam logic [4:0]  RES_18       = 5'h12;
	localparam logic [4:0]  RES_19       = 5'h13;
	localparam logic [4:0]  RES_22       = 5'h16;

	localparam logic [7:0]  OFF_CTRL     = 8'h00;
	localparam logic [7:0]  OFF_RES      = 8'h04;
	localparam logic [7:0]  OFF_STATUS   = 8'h08;
	localparam logic [7:0]  OFF_TSTAMP   = 8'h0c;
	localparam logic [7:0]  OFF_SHADOW   = 8'h10;

	localparam int          CTRL_USER_ZERO   = 0;
	localparam int          CTRL_FORCE_ALARM = 1;
	localparam logic [1:0]  CTRL_RST         = 2'h0;
	localparam logic [4:0]  RES_RST          = 5'h16;

endpackage : ssipmf_pkg

`default_nettype wire

// ### sim/ssipmf_ssi_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none

module ssipmf_ssi_ctrl_model (
	input  wire logic sdata_pin,
	output logic      sclk_pin
);

	// Clock rests high between reads
	initial sclk_pin = 1'b1;

	// One read of n bits, then the trailing bit and the update gap
	task automatic read_word(
		input  int          n,
		output logic [31:0] word,
		output logic        err_bit,
		output logic        held,
		output logic        back_high
	);
		word = '0;
		#37;
		sclk_pin = 1'b0;
		for (int i = 1; i <= n + 1; i++)
		begin
			#400;
			if (i > 1)
				word = {word[30:0], sdata_pin};
			sclk_pin = 1'b1;
			if (i <= n)
			begin
				#400;
				sclk_pin = 1'b0;
			end
		end
		#500;
		err_bit = sdata_pin;
		#18600;
		held = sdata_pin;
		#1500;
		back_high = sdata_pin;
	endtask : read_word

endmodule : ssipmf_ssi_ctrl_model

`default_nettype wire

// ### sim/ssi_position_message_formatter_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module ssi_position_message_formatter_tb_top;

	logic                     core_clk;
	logic                     rst;
	ssipmf_pkg::ssipmf_meas_s meas;
	logic                     sclk_pin;
	logic                     sdata_pin;
	logic                     sclk_two;
	logic                     sdata_two;
	logic                     psel;
	logic                     penable;
	logic                     pwrite;
	logic [7:0]               paddr;
	logic [31:0]              pwdata;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	int                       fail_count;
	int                       num_checks;

	ssipmf_formatter #(.FORMAT(ssipmf_pkg::format_six)) i_dut (
		.core_clk  (core_clk),
		.rst       (rst),
		.meas      (meas),
		.sclk_pin  (sclk_pin),
		.sdata_pin (sdata_pin),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr)
	);

	ssipmf_ssi_ctrl_model i_ctrl (
		.sdata_pin (sdata_pin),
		.sclk_pin  (sclk_pin)
	);

	ssipmf_formatter #(.FORMAT(ssipmf_pkg::format_two)) i_dut2 (
		.core_clk  (core_clk),
		.rst       (rst),
		.meas      (meas),
		.sclk_pin  (sclk_two),
		.sdata_pin (sdata_two),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.prdata    (),
		.pready    (),
		.pslverr   ()
	);

	ssipmf_ssi_ctrl_model i_ctrl2 (
		.sdata_pin (sdata_two),
		.sclk_pin  (sclk_two)
	);

	always #50 core_clk = ~core_clk;

	task automatic results();
		$display("Checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [31:0] exp_word(logic [21:0] pos, logic zdef, logic err);
		logic [23:0] low;
		logic [7:0]  crc;
		low = {~err, zdef, pos};
		crc = 8'h00;
		for (int i = 23; i >= 0; i--)
			crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ low[i]) ? ssipmf_pkg::CRC_POLY : 8'h00);
		return {crc, low};
	endfunction : exp_word

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		int n;
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= addr;
		pwdata <= wdata;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
		begin
			fail_count++;
			results();
		end
		rdata = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic reg_rw(input logic [7:0] addr, input logic [31:0] wdata, input logic [31:0] exp,
		input logic exp_err);
		logic [31:0] d;
		logic        e;
		apb(1'b1, addr, wdata, d, e);
		chk({31'h0, e}, {31'h0, exp_err});
		apb(1'b0, addr, 32'h0, d, e);
		chk(d, exp);
		chk({31'h0, e}, {31'h0, exp_err});
	endtask : reg_rw

	task automatic measure(input logic [21:0] pos, input logic err);
		@(posedge core_clk);
		meas <= {1'b1, err, pos};
		@(posedge core_clk);
		meas.strobe <= 1'b0;
	endtask : measure

	task automatic ssi_read(output logic [31:0] w, output logic e);
		logic h;
		logic b;
		@(posedge core_clk);
		i_ctrl.read_word(32, w, e, h, b);
		chk({31'h0, h}, {31'h0, e});
		chk({31'h0, b}, 32'h1);
	endtask : ssi_read

	task automatic t_basic();
		logic [31:0] w;
		logic        e;
		chk({31'h0, sdata_pin}, 32'h1);
		measure(22'h2a5c31, 1'b0);
		ssi_read(w, e);
		chk(w, exp_word(22'h2a5c31, 1'b1, 1'b0));
		chk({31'h0, e}, 32'h0);
		reg_rw(ssipmf_pkg::OFF_SHADOW, 32'h0, exp_word(22'h2a5c31, 1'b1, 1'b0), 1'b0);
		reg_rw(ssipmf_pkg::OFF_STATUS, 32'hffffffff, 32'h0000064b, 1'b0);
		$display("Test basic message done");
	endtask : t_basic

	task automatic t_regs();
		logic [31:0] w;
		logic        e;
		reg_rw(ssipmf_pkg::OFF_RES, 32'h1f, 32'h16, 1'b0);
		reg_rw(8'h20, 32'h5, 32'h0, 1'b1);
		reg_rw(ssipmf_pkg::OFF_CTRL, 32'h1, 32'h1, 1'b0);
		reg_rw(ssipmf_pkg::OFF_RES, 32'h10, 32'h10, 1'b0);
		measure(22'h3fffff, 1'b0);
		ssi_read(w, e);
		chk(w, exp_word(22'h00ffff, 1'b0, 1'b0));
		$display("Test registers and masking done");
	endtask : t_regs

	task automatic t_alarm();
		logic [31:0] w;
		logic        e;
		reg_rw(ssipmf_pkg::OFF_CTRL, 32'h3, 32'h3, 1'b0);
		measure(22'h001234, 1'b0);
		ssi_read(w, e);
		// Valid bit cleared while the alarm is forced, position still sent
		chk({31'h0, w[23]}, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("Test alarm done");
	endtask : t_alarm

	task automatic t_latch();
		logic [31:0] w;
		logic        e;
		reg_rw(ssipmf_pkg::OFF_CTRL, 32'h0, 32'h0, 1'b0);
		reg_rw(ssipmf_pkg::OFF_RES, 32'h16, 32'h16, 1'b0);
		measure(22'h0a0f0f, 1'b0);
		fork
			ssi_read(w, e);
			begin
				#5000;
				measure(22'h155555, 1'b0);
			end
		join
		chk(w, exp_word(22'h0a0f0f, 1'b1, 1'b0));
		ssi_read(w, e);
		chk(w, exp_word(22'h155555, 1'b1, 1'b0));
		$display("Test latch during read done");
	endtask : t_latch

	task automatic t_format_two();
		logic [31:0] w;
		logic        e;
		logic        h;
		logic        b;
		measure(22'h2a5c31, 1'b0);
		@(posedge core_clk);
		i_ctrl2.read_word(24, w, e, h, b);
		chk(w, {8'h00, 22'h2a5c31, ^22'h2a5c31, 1'b0});
		chk({31'h0, e}, 32'h0);
		chk({31'h0, h}, {31'h0, e});
		chk({31'h0, b}, 32'h1);
		reg_rw(ssipmf_pkg::OFF_CTRL, 32'h2, 32'h2, 1'b0);
		@(posedge core_clk);
		i_ctrl2.read_word(24, w, e, h, b);
		chk({31'h0, w[0]}, 32'h1);
		chk({31'h0, e}, 32'h1);
		chk({31'h0, h}, 32'h1);
		chk({31'h0, b}, 32'h1);
		reg_rw(ssipmf_pkg::OFF_CTRL, 32'h0, 32'h0, 1'b0);
		$display("Test format two done");
	endtask : t_format_two

	initial
	begin
		#3000000;
		$display("Watchdog expired");
		fail_count++;
		results();
	end

	initial
	begin
		core_clk = 1'b0;
		rst = 1'b1;
		meas = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fail_count = 0;
		num_checks = 0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		t_basic();
		t_regs();
		t_alarm();
		t_latch();
		t_format_two();
		results();
	end

endmodule : ssi_position_message_formatter_tb_top

`default_nettype wire
